// ==== bcic_map.svh ====
// Offsets, field positions, reset values and codes of the bridge header start
`ifndef BCIC_MAP_SVH
`define BCIC_MAP_SVH
`define BCIC_OFS_MAKER 8'h00
`define BCIC_OFS_PART 8'h02
`define BCIC_OFS_CMD 8'h04
`define BCIC_OFS_STAT 8'h06
`define BCIC_CMD_RESET 16'h0000
`define BCIC_CMD_RW_MASK 16'h0157
`define BCIC_CMD_IO_SPACE_BIT 0
`define BCIC_CMD_MEM_SPACE_BIT 1
`define BCIC_CMD_UP_INIT_BIT 2
`define BCIC_CMD_SPECIAL_BIT 3
`define BCIC_CMD_WI_PROMOTE_BIT 4
`define BCIC_CMD_PALETTE_BIT 5
`define BCIC_CMD_PARITY_RESP_BIT 6
`define BCIC_CMD_STEPPING_BIT 7
`define BCIC_CMD_SIGNALED_SYSTEM_ERR_FLAG_REP_BIT 8
`define BCIC_CMD_BACK_TO_BACK_BIT 9
`define BCIC_CMD_INT_DIS_BIT 10
`define BCIC_STAT_MASTER_PAR_BIT 8
`define BCIC_STAT_SIG_SIGNALED_SYSTEM_ERR_FLAG_BIT 14
`define BCIC_STAT_RESET 16'h0000
`define BCIC_MAKER_CODE_DEF 16'h5a5a
`define BCIC_PART_CODE_DEF 16'h0c3e
`endif

// ==== bcic_pkg.sv ====
// Types shared by the bridge header start
package bcic_pkg;
	typedef enum logic [2:0] {
		BCIC_REQ_MEM_RD,
		BCIC_REQ_MEM_WR,
		BCIC_REQ_IO_RD,
		BCIC_REQ_IO_WR,
		BCIC_REQ_OTHER
	} bcic_req_kind_t;
	typedef enum logic {
		BCIC_ERR_IDLE,
		BCIC_ERR_SEND
	} bcic_err_state_t;
endpackage

// ==== bcic_down_filter.sv ====
// Downstream request filter: accept or unsupported, promotion, poison forwarding
`timescale 1ns/1ps
module bcic_down_filter (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic dnValid,
	input wire bcic_pkg::bcic_req_kind_t dnKind,
	input wire logic dnPoisoned,
	input wire logic memSpaceEn,
	input wire logic ioSpaceEn,
	input wire logic promoteEn,
	output logic dnAccept,
	output logic dnUnsupported,
	output logic dnPromoteMwi,
	output logic dnFwdBadParity,
	output logic poisonWrEvent
);
	logic isMem;
	logic isIo;
	logic isWr;
	logic okNxt;

	assign isMem = (dnKind == bcic_pkg::BCIC_REQ_MEM_RD) || (dnKind == bcic_pkg::BCIC_REQ_MEM_WR);
	assign isIo = (dnKind == bcic_pkg::BCIC_REQ_IO_RD) || (dnKind == bcic_pkg::BCIC_REQ_IO_WR);
	assign isWr = (dnKind == bcic_pkg::BCIC_REQ_MEM_WR) || (dnKind == bcic_pkg::BCIC_REQ_IO_WR);
	// Other kinds are not this block's to judge; passed as accepted
	assign okNxt = (isMem & memSpaceEn) | (isIo & ioSpaceEn) | (~isMem & ~isIo); // R17 R19

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dnAccept <= 1'b0;
			dnUnsupported <= 1'b0;
			dnPromoteMwi <= 1'b0;
			dnFwdBadParity <= 1'b0;
			poisonWrEvent <= 1'b0;
		end else begin
			dnAccept <= dnValid & okNxt;
			dnUnsupported <= dnValid & ~okNxt; // R16 R18
			dnPromoteMwi <= dnValid & okNxt & promoteEn & (dnKind == bcic_pkg::BCIC_REQ_MEM_WR); // R12
			// Bad parity goes out whatever the parity response bit says
			dnFwdBadParity <= dnValid & okNxt & isWr & dnPoisoned; // R10
			poisonWrEvent <= dnValid & okNxt & isWr & dnPoisoned;
		end
	end
endmodule

// ==== bcic_up_gate.sv ====
// Upstream gating and error message sender for system errors seen on PCI
`timescale 1ns/1ps
module bcic_up_gate (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic upInitEn,
	input wire logic sysErrRepEn,
	input wire logic serrPin_b,
	input wire logic serrIsFatal,
	input wire logic pciMemIoReq,
	input wire logic pciSpecialCycle,
	input wire logic upReqValid,
	output logic pciClaim,
	output logic upReqGo,
	output logic errMsgValid,
	output logic errMsgFatal,
	input wire logic errMsgReady,
	output logic sigSysErrEvent
);
	logic serrMeta_r;
	logic serrSync_r;
	logic serrSeen_r;
	bcic_pkg::bcic_err_state_t errState_r;

	assign pciClaim = pciMemIoReq & ~pciSpecialCycle & upInitEn; // R13 R14 R15
	assign upReqGo = upReqValid & upInitEn; // R14
	assign errMsgValid = (errState_r == bcic_pkg::BCIC_ERR_SEND) & sysErrRepEn; // R07
	assign sigSysErrEvent = errMsgValid & errMsgReady; // R20

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			serrMeta_r <= 1'b0;
			serrSync_r <= 1'b0;
			serrSeen_r <= 1'b0;
		end else begin
			serrMeta_r <= ~serrPin_b;
			serrSync_r <= serrMeta_r;
			serrSeen_r <= serrSync_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			errState_r <= bcic_pkg::BCIC_ERR_IDLE;
			errMsgFatal <= 1'b0;
		end else begin
			unique case (errState_r)
				bcic_pkg::BCIC_ERR_IDLE: begin
					// Reporting disabled: assertion is dropped, not queued
					if (serrSync_r & ~serrSeen_r & sysErrRepEn) begin // R07
						errState_r <= bcic_pkg::BCIC_ERR_SEND;
						errMsgFatal <= serrIsFatal;
					end
				end
				bcic_pkg::BCIC_ERR_SEND: begin
					if (sigSysErrEvent | ~sysErrRepEn) begin
						errState_r <= bcic_pkg::BCIC_ERR_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// ==== bcic_cfg_regs.sv ====
// Identification words, command word and two status flags of the bridge header
//
// Notes on behaviour
// R01 - Offset 00h returns a fixed maker code; writes do nothing.
// R02 - Offset 02h returns a fixed part code; writes do nothing.
// R03 - Command word at 04h, mixed access, resets to all zero.
// R04 - Command bits 15 to 11 always read zero.
// R05 - Interrupt disable bit 10 is read-only zero.
// R06 - Back-to-back enable bit 9 reads zero.
// R07 - Bit 8 enables error messages for PCI system errors; else suppressed.
// R08 - Stepping bit 7 is hardwired zero.
// R09 - Bit 6 gates poisoned TLPs setting the master parity error flag.
// R10 - Poisoned TLPs are forwarded with bad parity regardless of bit 6.
// R11 - Palette snoop bit 5 reads zero.
// R12 - Bit 4 promotes memory writes to write-and-invalidate cycles.
// R13 - Special cycle bit 3 reads zero; special cycles are ignored.
// R14 - Bit 2 low: no upstream requests, no PCI memory or I/O claims.
// R15 - Bit 2 high: PCI memory and I/O may be claimed and forwarded.
// R16 - Bit 1 low: downstream memory requests get unsupported request.
// R17 - Bit 1 high: downstream memory requests are accepted.
// R18 - Bit 0 low: downstream I/O requests get unsupported request.
// R19 - Bit 0 high: downstream I/O requests are accepted.
// R20 - Status bit 14 sets when an error message goes out with bit 8 set.
// R21 - Status bit 8 sets on poisoned completion or poisoned write, if enabled.
// R22 - Writes change only writable command bits; others discarded silently.
`timescale 1ns/1ps
`include "bcic_map.svh"
module bcic_cfg_regs #(
	// Arbitrary identification values
	parameter logic [15:0] MAKER_CODE = `BCIC_MAKER_CODE_DEF,
	parameter logic [15:0] PART_CODE = `BCIC_PART_CODE_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	// Configuration access, one dword per request
	input wire logic cfgReq,
	input wire logic cfgWr,
	input wire logic [7:0] cfgAddr,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgWrData,
	output logic cfgAck,
	output logic [31:0] cfgRdData,
	// Downstream requests from the link side
	input wire logic dnValid,
	input wire bcic_pkg::bcic_req_kind_t dnKind,
	input wire logic dnPoisoned,
	output logic dnAccept,
	output logic dnUnsupported,
	output logic dnPromoteMwi,
	output logic dnFwdBadParity,
	// Completions and secondary bus decode
	input wire logic cplPoisoned,
	input wire logic pciMemIoReq,
	input wire logic pciSpecialCycle,
	output logic pciClaim,
	input wire logic upReqValid,
	output logic upReqGo,
	// System error pin and upstream message handshake
	input wire logic serrPin_b,
	input wire logic serrIsFatal,
	output logic errMsgValid,
	output logic errMsgFatal,
	input wire logic errMsgReady,
	// Register views for the rest of the bridge
	output logic [15:0] commandWord,
	output logic masterParityErrFlag,
	output logic signaledSystemErrFlag
);

	////////////////////////////////////////////////////////////////////////
	// Command word and its fields

	logic [15:0] command_control_r;
	logic [15:0] command_control_nxt;
	logic [15:0] statusWord;
	logic [15:0] cmdView;
	logic system_error_report_en;
	logic parity_response_en;
	logic write_invalidate_promote_en;
	logic upstream_initiate_en;
	logic mem_space_en;
	logic io_space_en;
	logic back_to_back_en;
	logic stepping_en;
	logic palette_snoop_en;
	logic poisonWrEvent;
	logic sigSysErrEvent;

	assign system_error_report_en = command_control_r[`BCIC_CMD_SIGNALED_SYSTEM_ERR_FLAG_REP_BIT];
	assign parity_response_en = command_control_r[`BCIC_CMD_PARITY_RESP_BIT];
	assign write_invalidate_promote_en = command_control_r[`BCIC_CMD_WI_PROMOTE_BIT];
	assign upstream_initiate_en = command_control_r[`BCIC_CMD_UP_INIT_BIT];
	assign mem_space_en = command_control_r[`BCIC_CMD_MEM_SPACE_BIT];
	assign io_space_en = command_control_r[`BCIC_CMD_IO_SPACE_BIT];
	// Hardwired: the bridge has none of these features
	assign back_to_back_en = 1'b0; // R06
	assign stepping_en = 1'b0; // R08
	assign palette_snoop_en = 1'b0; // R11
	assign commandWord = cmdView;

	////////////////////////////////////////////////////////////////////////
	// Access decoding

	// Dword holding a byte offset, matched on bits 7:2
	function automatic logic hitsDword(input logic [7:0] addr, input logic [7:0] ofs);
		hitsDword = (addr[7:2] == ofs[7:2]);
	endfunction

	// Byte enables of the half of a dword that holds a 16-bit word
	function automatic logic [1:0] halfEnables(input logic [3:0] be, input logic [7:0] ofs);
		halfEnables = ofs[1] ? be[3:2] : be[1:0];
	endfunction

	logic cmdDwordHit;
	logic identDwordHit;
	logic cfgWrCmd;
	logic [1:0] cmdBe;
	logic [1:0] statBe;
	logic [15:0] cmdWrHalf;
	logic [15:0] statWrHalf;
	logic [15:0] cmdLaneMask;

	assign cmdDwordHit = hitsDword(cfgAddr, `BCIC_OFS_CMD);
	assign identDwordHit = hitsDword(cfgAddr, `BCIC_OFS_MAKER);
	// Writes to the identification dword have no path to any state
	assign cfgWrCmd = cfgReq & cfgWr & cmdDwordHit; // R01 R02 R22
	assign cmdBe = halfEnables(cfgByteEn, `BCIC_OFS_CMD);
	assign statBe = halfEnables(cfgByteEn, `BCIC_OFS_STAT);
	assign cmdWrHalf = cfgWrData[15:0];
	assign statWrHalf = cfgWrData[31:16];

	genvar lane;
	generate
		for (lane = 0; lane < 2; lane++) begin : gLane
			assign cmdLaneMask[lane*8 +: 8] = {8{cmdBe[lane]}};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Command register update

	always_comb begin
		command_control_nxt = command_control_r;
		if (cfgWrCmd) begin
			// Only writable bits under an enabled byte lane move
			command_control_nxt = (command_control_r & ~(cmdLaneMask & `BCIC_CMD_RW_MASK))
				| (cmdWrHalf & cmdLaneMask & `BCIC_CMD_RW_MASK); // R22 R04 R05 R06 R08 R11 R13
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			command_control_r <= `BCIC_CMD_RESET; // R03
		end else begin
			command_control_r <= command_control_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command word as software and the datapath see it

	// Built field by field so a stray register bit can never leak out
	always_comb begin
		cmdView = 16'h0000; // R04
		cmdView[`BCIC_CMD_IO_SPACE_BIT] = io_space_en;
		cmdView[`BCIC_CMD_MEM_SPACE_BIT] = mem_space_en;
		cmdView[`BCIC_CMD_UP_INIT_BIT] = upstream_initiate_en;
		cmdView[`BCIC_CMD_SPECIAL_BIT] = 1'b0; // R13
		cmdView[`BCIC_CMD_WI_PROMOTE_BIT] = write_invalidate_promote_en;
		cmdView[`BCIC_CMD_PALETTE_BIT] = palette_snoop_en; // R11
		cmdView[`BCIC_CMD_PARITY_RESP_BIT] = parity_response_en;
		cmdView[`BCIC_CMD_STEPPING_BIT] = stepping_en; // R08
		cmdView[`BCIC_CMD_SIGNALED_SYSTEM_ERR_FLAG_REP_BIT] = system_error_report_en;
		cmdView[`BCIC_CMD_BACK_TO_BACK_BIT] = back_to_back_en; // R06
		cmdView[`BCIC_CMD_INT_DIS_BIT] = 1'b0; // R05
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags fed by the command bits

	logic [1:0] flagSet;
	logic [1:0] flagClr;
	logic [1:0] flag_r;

	assign flagSet[0] = parity_response_en & (cplPoisoned | poisonWrEvent); // R09 R21
	assign flagSet[1] = sigSysErrEvent & system_error_report_en; // R20
	// Write one to clear, status half of the command dword
	assign flagClr[0] = cfgWrCmd & statBe[1] & statWrHalf[`BCIC_STAT_MASTER_PAR_BIT];
	assign flagClr[1] = cfgWrCmd & statBe[1] & statWrHalf[`BCIC_STAT_SIG_SIGNALED_SYSTEM_ERR_FLAG_BIT];

	generate
		for (genvar f = 0; f < 2; f++) begin : gFlag
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					flag_r[f] <= 1'b0;
				end else if (flagSet[f]) begin
					// A new event beats a clear in the same cycle
					flag_r[f] <= 1'b1;
				end else if (flagClr[f]) begin
					flag_r[f] <= 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		statusWord = `BCIC_STAT_RESET;
		statusWord[`BCIC_STAT_MASTER_PAR_BIT] = flag_r[0];
		statusWord[`BCIC_STAT_SIG_SIGNALED_SYSTEM_ERR_FLAG_BIT] = flag_r[1];
	end

	assign masterParityErrFlag = flag_r[0];
	assign signaledSystemErrFlag = flag_r[1];

	////////////////////////////////////////////////////////////////////////
	// Read path, answered one cycle after the request

	logic [31:0] rdNxt;

	// Read data holds between reads, so a slow host may take it late
	always_comb begin
		rdNxt = 32'h0000_0000;
		if (identDwordHit) begin
			rdNxt = {PART_CODE, MAKER_CODE}; // R01 R02
		end else if (cmdDwordHit) begin
			rdNxt = {statusWord, cmdView}; // R04 R05
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfgAck <= 1'b0;
			cfgRdData <= 32'h0000_0000;
		end else begin
			cfgAck <= cfgReq;
			if (cfgReq & ~cfgWr) begin
				cfgRdData <= rdNxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Datapath gates

	// Both gates see the registered command: a write acts from the next cycle
	bcic_down_filter uDown (
		.clk(clk),
		.rst_b(rst_b),
		.dnValid(dnValid),
		.dnKind(dnKind),
		.dnPoisoned(dnPoisoned),
		.memSpaceEn(mem_space_en), // R16 R17
		.ioSpaceEn(io_space_en), // R18 R19
		.promoteEn(write_invalidate_promote_en), // R12
		.dnAccept(dnAccept),
		.dnUnsupported(dnUnsupported),
		.dnPromoteMwi(dnPromoteMwi),
		.dnFwdBadParity(dnFwdBadParity), // R10
		.poisonWrEvent(poisonWrEvent)
	);

	bcic_up_gate uUp (
		.clk(clk),
		.rst_b(rst_b),
		.upInitEn(upstream_initiate_en), // R14 R15
		.sysErrRepEn(system_error_report_en), // R07
		.serrPin_b(serrPin_b),
		.serrIsFatal(serrIsFatal),
		.pciMemIoReq(pciMemIoReq),
		.pciSpecialCycle(pciSpecialCycle), // R13
		.upReqValid(upReqValid),
		.pciClaim(pciClaim),
		.upReqGo(upReqGo),
		.errMsgValid(errMsgValid),
		.errMsgFatal(errMsgFatal),
		.errMsgReady(errMsgReady),
		.sigSysErrEvent(sigSysErrEvent)
	);

endmodule

// ==== bcic_cfg_regs_asserts.sv ====
// Concurrent checks on the ports of the bridge header start
`timescale 1ns/1ps
`include "bcic_map.svh"
module bcic_cfg_regs_chk #(
	parameter logic [15:0] MAKER_CODE = `BCIC_MAKER_CODE_DEF,
	parameter logic [15:0] PART_CODE = `BCIC_PART_CODE_DEF
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cfgReq,
	input wire logic cfgWr,
	input wire logic [7:0] cfgAddr,
	input wire logic [31:0] cfgWrData,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgRdData,
	input wire logic dnValid,
	input wire bcic_pkg::bcic_req_kind_t dnKind,
	input wire logic dnPoisoned,
	input wire logic dnAccept,
	input wire logic dnUnsupported,
	input wire logic dnPromoteMwi,
	input wire logic dnFwdBadParity,
	input wire logic cplPoisoned,
	input wire logic pciMemIoReq,
	input wire logic pciSpecialCycle,
	input wire logic pciClaim,
	input wire logic upReqValid,
	input wire logic upReqGo,
	input wire logic errMsgValid,
	input wire logic errMsgReady,
	input wire logic [15:0] commandWord,
	input wire logic masterParityErrFlag,
	input wire logic signaledSystemErrFlag
);
	wire cmdWr = cfgReq && cfgWr && cfgAddr[7:2] == 6'h01;
	wire [15:0] wrLow = cfgWrData[15:0];
	wire isMem = dnKind inside {bcic_pkg::BCIC_REQ_MEM_RD, bcic_pkg::BCIC_REQ_MEM_WR};
	wire isIo = dnKind inside {bcic_pkg::BCIC_REQ_IO_RD, bcic_pkg::BCIC_REQ_IO_WR};
	wire memWr = dnValid && dnKind == bcic_pkg::BCIC_REQ_MEM_WR && commandWord[1];
	wire memEn = commandWord[1];
	wire ioEn = commandWord[0];
	wire promEn = commandWord[4];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////
	a_fixed_zeros: assert property ((commandWord & ~`BCIC_CMD_RW_MASK) == 16'h0000)
		else $error("read-only command bit set");
	a_cmd_written: assert property (cmdWr && cfgByteEn[1:0] == 2'h3 |=> commandWord == ($past(wrLow) & 16'h0157))
		else $error("command write not taken");
	a_cmd_hold: assert property (!cmdWr |=> $stable(commandWord))
		else $error("command changed without write");
	a_ident_read: assert property (cfgReq && !cfgWr && cfgAddr[7:2] == 6'h00 |=> cfgRdData == {PART_CODE, MAKER_CODE})
		else $error("ident word wrong");
	a_mem_gate: assert property (dnValid && isMem |=> dnAccept == $past(memEn) && dnUnsupported == !$past(memEn))
		else $error("memory request answer wrong");
	a_io_gate: assert property (dnValid && isIo |=> dnAccept == $past(ioEn) && dnUnsupported == !$past(ioEn))
		else $error("io request answer wrong");
	a_promote_gate: assert property (memWr |=> dnPromoteMwi == $past(promEn))
		else $error("promotion wrong");
	a_poison_fwd: assert property (memWr && dnPoisoned |=> dnFwdBadParity)
		else $error("poisoned write not forwarded bad");
	a_claim_gate: assert property (pciClaim == (pciMemIoReq && !pciSpecialCycle && commandWord[2]))
		else $error("claim gating wrong");
	a_up_gate: assert property (upReqGo == (upReqValid && commandWord[2]))
		else $error("upstream gating wrong");
	a_msg_enable: assert property (errMsgValid |-> commandWord[8])
		else $error("message without enable");
	a_sys_flag: assert property (errMsgValid && errMsgReady |=> signaledSystemErrFlag)
		else $error("system error flag not set");
	a_par_flag: assert property (cplPoisoned && commandWord[6] |=> masterParityErrFlag)
		else $error("parity flag not set");
endmodule
bind bcic_cfg_regs bcic_cfg_regs_chk #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) i_chk (.clk, .rst_b, .cfgReq,
	.cfgWr, .cfgAddr, .cfgWrData, .cfgByteEn, .cfgRdData, .dnValid, .dnKind, .dnPoisoned, .dnAccept, .dnUnsupported,
	.dnPromoteMwi, .dnFwdBadParity, .cplPoisoned, .pciMemIoReq, .pciSpecialCycle, .pciClaim, .upReqValid, .upReqGo,
	.errMsgValid, .errMsgReady, .commandWord, .masterParityErrFlag, .signaledSystemErrFlag);

// ==== bcic_msg_sink.sv ====
// Upstream receiver that takes error messages after a chosen wait
`timescale 1ns/1ps
module bcic_msg_sink (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic errMsgValid,
	input wire logic [3:0] waitCycles,
	output logic errMsgReady
);
	logic [3:0] waitCnt_r;
	// Ready never raised ahead of a message, so a sender cannot lean on it
	always_ff @(posedge clk) begin
		if (!rst_b || !errMsgValid || errMsgReady) begin
			waitCnt_r <= 4'h0;
		end else begin
			waitCnt_r <= waitCnt_r + 4'h1;
		end
	end
	assign errMsgReady = errMsgValid && waitCnt_r >= waitCycles;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the bridge header start
`timescale 1ns/1ps
`include "bcic_map.svh"
module tb_top;
	logic clk = 1'h0, rst_b = 1'h0, cfgReq = 1'h0, cfgWr = 1'h0, dnValid = 1'h0, dnPoisoned = 1'h0;
	logic cplPoisoned = 1'h0, pciMemIoReq = 1'h0, pciSpecialCycle = 1'h0, upReqValid = 1'h0, serrPin_b = 1'h1;
	logic serrIsFatal = 1'h0, parF = 1'h0, sysF = 1'h0;
	logic [7:0] cfgAddr = '0;
	logic [3:0] cfgByteEn = '0, waitCycles = '0;
	logic [31:0] cfgWrData = '0, cfgRdData, d;
	bcic_pkg::bcic_req_kind_t dnKind = bcic_pkg::BCIC_REQ_OTHER;
	logic cfgAck, dnAccept, dnUnsupported, dnPromoteMwi, dnFwdBadParity, pciClaim, upReqGo;
	logic errMsgValid, errMsgFatal, errMsgReady, masterParityErrFlag, signaledSystemErrFlag;
	logic [15:0] commandWord, cmd = '0;
	logic [32:0] rdQ[$];
	logic [3:0] dnQ[$];
	integer seed = 32'h78f6, failures = 0, check_count = 0, i, n;
	always #25 clk = ~clk;
	bcic_cfg_regs i_dut (.clk, .rst_b, .cfgReq, .cfgWr, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgAck, .cfgRdData,
		.dnValid, .dnKind, .dnPoisoned, .dnAccept, .dnUnsupported, .dnPromoteMwi, .dnFwdBadParity, .cplPoisoned,
		.pciMemIoReq, .pciSpecialCycle, .pciClaim, .upReqValid, .upReqGo, .serrPin_b, .serrIsFatal, .errMsgValid,
		.errMsgFatal, .errMsgReady, .commandWord, .masterParityErrFlag, .signaledSystemErrFlag);
	bcic_msg_sink i_sink (.clk, .rst_b, .errMsgValid, .waitCycles, .errMsgReady);
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			failures++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up();
		check(rdQ.size() + dnQ.size(), 0);
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
		@(negedge clk);
		{cfgReq, cfgWr, cfgAddr, cfgByteEn, cfgWrData} = {1'h1, wr, a, be, wd};
		if (wr && a == 8'h04 && be[1:0] == 2'h3) cmd = wd[15:0] & `BCIC_CMD_RW_MASK;
		if (wr && a == 8'h04 && be[3]) {sysF, parF} = {sysF & !wd[30], parF & !wd[24]};
		if (a[7:2] == 6'h00) rdQ.push_back({!wr, `BCIC_PART_CODE_DEF, `BCIC_MAKER_CODE_DEF});
		else if (a[7:2] == 6'h01) rdQ.push_back({!wr, 1'h0, sysF, 5'h00, parF, 8'h00, cmd});
		else rdQ.push_back({!wr, 32'h00000000});
		@(negedge clk);
		cfgReq = 1'h0;
	endtask
	task automatic dn(input bcic_pkg::bcic_req_kind_t k, input logic p);
		logic acc;
		acc = (k inside {bcic_pkg::BCIC_REQ_MEM_RD, bcic_pkg::BCIC_REQ_MEM_WR}) ? cmd[1] :
			(k inside {bcic_pkg::BCIC_REQ_IO_RD, bcic_pkg::BCIC_REQ_IO_WR}) ? cmd[0] : 1'h1;
		@(negedge clk);
		{dnValid, dnKind, dnPoisoned} = {1'h1, k, p};
		dnQ.push_back({acc, !acc, acc && k == bcic_pkg::BCIC_REQ_MEM_WR && cmd[4], acc && p});
		if (acc && p && cmd[6]) parF = 1'h1;
		@(negedge clk);
		dnValid = 1'h0;
	endtask
	always @(negedge clk) {pciMemIoReq, pciSpecialCycle, upReqValid} = 3'($random(seed));
	// Results sampled after the edge has settled
	always @(posedge clk) begin
		#1;
		check(commandWord, cmd);
		check({pciClaim, upReqGo}, {pciMemIoReq & ~pciSpecialCycle & cmd[2], upReqValid & cmd[2]});
		if (cfgAck === 1'h1) begin
			if (rdQ[0][32]) check(cfgRdData, rdQ[0][31:0]);
			void'(rdQ.pop_front());
		end
		if ((dnAccept | dnUnsupported) === 1'h1) begin
			check({dnAccept, dnUnsupported, dnPromoteMwi, dnFwdBadParity}, dnQ.pop_front());
		end
	end
	initial begin
		#2000000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk) rst_b = 1'h1;
		cfg(1'h0, 8'h04, 4'hf, 32'h0);
		cfg(1'h1, 8'h00, 4'hf, $random(seed));
		cfg(1'h1, 8'h08, 4'hf, $random(seed));
		cfg(1'h0, 8'h00, 4'hf, 32'h0);
		cfg(1'h0, 8'h08, 4'hf, 32'h0);
		$display("ident and reset test done");
		cfg(1'h1, 8'h04, 4'h3, 32'hffffffff);
		cfg(1'h0, 8'h04, 4'hf, 32'h0);
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			d[1:0] = i[1:0];
			d[4] = i[2];
			cfg(1'h1, 8'h04, 4'h3, d);
			for (n = 0; n < 5; n++) dn(bcic_pkg::bcic_req_kind_t'(n), n == 1 && 1'($random(seed)));
			cfg(1'h0, 8'h04, 4'hf, 32'h0);
			cfg(1'h1, 8'h04, 4'h8, 32'h41000000);
		end
		$display("command and downstream test done");
		for (i = 0; i < 2; i++) begin
			cfg(1'h1, 8'h04, 4'h3, {25'h0, i[0], 6'h0});
			@(negedge clk) cplPoisoned = 1'h1;
			@(negedge clk) cplPoisoned = 1'h0;
			parF = parF | i[0];
			cfg(1'h0, 8'h04, 4'hf, 32'h0);
		end
		cfg(1'h1, 8'h04, 4'h8, 32'h01000000);
		cfg(1'h0, 8'h04, 4'hf, 32'h0);
		$display("parity flag test done");
		for (i = 0; i < 3; i++) begin
			cfg(1'h1, 8'h04, 4'h3, {23'h0, i < 2, 8'h04});
			{waitCycles, serrIsFatal} = {i[0] ? 4'h5 : 4'h0, 1'($random(seed))};
			@(negedge clk) serrPin_b = 1'h0;
			for (n = 0; n < 20 && errMsgValid !== 1'h1; n++) @(negedge clk);
			serrPin_b = 1'h1;
			if (i < 2) check({errMsgValid, errMsgFatal}, {1'h1, serrIsFatal});
			else check(errMsgValid, 1'h0);
			for (n = 0; n < 20 && errMsgValid === 1'h1; n++) @(negedge clk);
			sysF = sysF | (i < 2);
			cfg(1'h0, 8'h04, 4'hf, 32'h0);
		end
		cfg(1'h1, 8'h04, 4'h8, 32'h40000000);
		cfg(1'h0, 8'h04, 4'hf, 32'h0);
		$display("system error test done");
		cfg(1'h1, 8'h04, 4'h3, 32'h0157);
		@(negedge clk) rst_b = 1'h0;
		{cmd, parF, sysF} = 18'h0;
		repeat (2) @(negedge clk);
		rst_b = 1'h1;
		cfg(1'h0, 8'h04, 4'hf, 32'h0);
		$display("second reset test done");
		repeat (3) @(negedge clk);
		wrap_up();
	end
endmodule
